// >>> include/dpa_pkg.sv
/*
 * Shared constants of the digital pin data and alternate-function block:
 * register indices, field positions, reset values and
 * selector encodings.
 * Assumes an APB master with 16-bit byte addresses and 32-bit data.
 */
package dpa_pkg;

    // ****************************************************************
    // Bus geometry
    // ****************************************************************
    localparam int AW = 16;
    localparam int DW = 32;
    localparam int PIN_LO = 16;

    // ****************************************************************
    // Register indices; byte address is four times the index
    // ****************************************************************
    localparam logic [AW-1:0] IDX_GRP0 = 16'h0080;
    localparam logic [AW-1:0] IDX_GRP1 = 16'h0090;
    localparam logic [AW-1:0] IDX_GRP2 = 16'h00A0;
    localparam logic [AW-1:0] IDX_GRP3 = 16'h00B0;
    localparam logic [AW-1:0] IDX_EEX = 16'h2456;
    localparam logic [AW-1:0] IDX_PVW = 16'h2457;
    localparam logic [AW-1:0] IDX_PX = 16'h2458;
    localparam logic [AW-1:0] IDX_MAP = 16'h2460;
    localparam logic [AW-1:0] IDX_HIDATA = 16'h2461;
    localparam logic [AW-1:0] IDX_HIDIR = 16'h2462;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int GRP_DATA_LSB = 0;
    localparam int GRP_DIR_LSB = 4;
    localparam int GRP_W = 4;
    localparam int GRP_SEL_LSB = 6;
    localparam int EEX_LSB = 6;
    localparam int PV_BIT = 6;
    localparam int PW_BIT = 7;
    localparam int PX_BIT = 7;

    // ****************************************************************
    // Pins with an alternate use
    // ****************************************************************
    localparam int PIN_PW = 0;
    localparam int PIN_PV = 1;
    localparam int PIN_EE_CLK = 2;
    localparam int PIN_EE_IO = 3;
    localparam int PIN_PX = 6;

    // ****************************************************************
    // Reset values and encodings
    // ****************************************************************
    localparam logic [1:0] EEX_OFF = 2'h0;
    localparam logic [1:0] EEX_TWO_WIRE = 2'h1;
    localparam logic [1:0] EEX_ALT = 2'h2;
    localparam logic [1:0] EEX_SPLIT = 2'h3;
    localparam logic [1:0] EEX_RST = EEX_OFF;
    localparam logic ROUTE_RST = 1'b0;
    localparam logic DIR_RST = 1'b0;
    localparam logic DATA_RST = 1'b0;
    localparam logic MAP_RST = 1'b0;

    typedef enum logic [3:0] {
        DPA_REG_NONE,
        DPA_REG_GRP,
        DPA_REG_EEX,
        DPA_REG_PVW,
        DPA_REG_PX,
        DPA_REG_MAP,
        DPA_REG_HIDATA,
        DPA_REG_HIDIR
    } dpa_reg_t;

endpackage

// >>> include/dpa_route_if.sv
/*
 * Routing controls passed from the register side to the pin driver.
 * Assumes both ends sit in the clk_sys domain.
 */
`timescale 1ns/100ps
interface dpa_route_if #(parameter int NPIN = 24);
    logic [NPIN-1:0] out_data;
    logic [NPIN-1:0] dir;
    logic [NPIN-1:0] display_pin_mapping;
    logic [1:0]      ee_sel;
    logic            pv_en;
    logic            pw_en;
    logic            px_en;

    modport ctl (output out_data, dir, display_pin_mapping, ee_sel, pv_en, pw_en, px_en);
    modport mux (input out_data, dir, display_pin_mapping, ee_sel, pv_en, pw_en, px_en);
endinterface

// >>> sim/dpa_far_side.sv
/*
 * Far side of the pins: board levels and a serial EEPROM
 * that pulls the data line low when it answers.
 * Assumes the device pins are split into level, enable and input.
 */
`timescale 1ns/100ps
module dpa_far_side
    import dpa_pkg::*;
#(
    parameter int NPIN = 24
) (
    // Device side
    input wire logic [NPIN-1:0] pin_out,
    input wire logic [NPIN-1:0] pin_oe,
    // Board side
    input wire logic [NPIN-1:0] ext_lvl,
    input wire logic            ee_ack,
    output logic     [NPIN-1:0] pin_in
);
    // ************************************************
    // Wire levels
    // ************************************************
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
        end
        // Open-drain data line: the EEPROM only wins while the device lets go
        if (ee_ack && !pin_oe[PIN_EE_IO]) begin
            pin_in[PIN_EE_IO] = 1'b0;
        end
    end
endmodule

// >>> sim/dpa_props.sv
/*
 * Checker of dpa_top: APB timing and routing of pulse and EEPROM pins.
 * Assumes it is bound onto dpa_top; map, selector, W and X route registers are shadowed here.
 */
`timescale 1ns/100ps
module dpa_props
    import dpa_pkg::*;
#(
    parameter int NPIN = 24
) (
    // Clock and reset
    input wire logic            clk_sys,
    input wire logic            rst,
    // APB
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [AW-1:0]   paddr,
    input wire logic [DW-1:0]   pwdata,
    input wire logic [DW-1:0]   prdata,
    input wire logic            pready,
    input wire logic            pslverr,
    // Pins and sources
    input wire logic [NPIN-1:0] pin_out,
    input wire logic [NPIN-1:0] pin_oe,
    input wire logic            real_energy_pulse,
    input wire logic            aux_x_pulse,
    input wire logic            ee_ctl_clock,
    input wire logic            ee_ctl_dout,
    input wire logic            ee_ctl_din,
    input wire logic [1:0]      ee_mode
);
    logic [NPIN-1:0] sh_map_q;
    logic [1:0]      sh_sel_q;
    logic            sh_pw_q;
    logic            sh_px_q;

    // ************************************************
    // Shadow of routing registers
    // ************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sh_map_q <= '0;
            sh_sel_q <= EEX_OFF;
            sh_pw_q <= 1'b0;
            sh_px_q <= 1'b0;
        end else if (psel && penable && pready && pwrite) begin
            case (paddr)
                IDX_MAP << 2: sh_map_q <= pwdata[NPIN-1:0];
                IDX_EEX << 2: sh_sel_q <= pwdata[EEX_LSB+:2];
                IDX_PVW << 2: sh_pw_q <= pwdata[PW_BIT];
                IDX_PX << 2: sh_px_q <= pwdata[PX_BIT];
                default: ;
            endcase
        end
    end

    // ************************************************
    // Properties
    // ************************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Three cycles cover register stage plus pin flop
    sequence s_ee_on;
        (sh_sel_q != EEX_OFF && !sh_map_q[PIN_EE_CLK] && !sh_map_q[PIN_EE_IO]) [*3];
    endsequence
    sequence s_split;
        (sh_sel_q == EEX_SPLIT && !sh_map_q[PIN_EE_CLK] && !sh_map_q[PIN_EE_IO]) [*3];
    endsequence
    sequence s_w_on;
        (sh_pw_q && !sh_map_q[PIN_PW]) [*3];
    endsequence
    sequence s_x_on;
        (sh_px_q && !sh_map_q[PIN_PX]) [*3];
    endsequence

    a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_write_reads_zero: assert property (pready && (pwrite || pslverr) |-> prdata == 32'h0)
        else $error("prdata not zero");
    a_mode_follows_sel: assert property (ee_mode == $past(sh_sel_q))
        else $error("ee_mode wrong");
    a_din_idle_high: assert property ((sh_sel_q == EEX_OFF) [*3] |-> ee_ctl_din)
        else $error("ee_ctl_din low while off");
    a_eeprom_clock_pin: assert property (s_ee_on |-> pin_oe[PIN_EE_CLK] &&
        pin_out[PIN_EE_CLK] == $past(ee_ctl_clock)) else $error("clock pin wrong");
    a_split_data_pin: assert property (s_split |-> pin_oe[PIN_EE_IO] &&
        pin_out[PIN_EE_IO] == $past(ee_ctl_dout)) else $error("data pin wrong");
    a_real_energy_pulse_pin_zero: assert property (s_w_on |-> pin_oe[PIN_PW] &&
        pin_out[PIN_PW] == $past(real_energy_pulse)) else $error("pin 0 pulse wrong");
    a_aux_x_pulse_pin_six: assert property (s_x_on |-> pin_oe[PIN_PX] &&
        pin_out[PIN_PX] == $past(aux_x_pulse)) else $error("pin 6 pulse wrong");
endmodule

bind dpa_top dpa_props #(.NPIN(NPIN)) u_props (
    .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pin_out, .pin_oe, .real_energy_pulse, .aux_x_pulse, .ee_ctl_clock,
    .ee_ctl_dout, .ee_ctl_din, .ee_mode
);

// >>> sim/dpa_top_bench.sv
/*
 * Testbench of dpa_top: APB register accesses and pin checks.
 * Assumes dpa_far_side closes the pins and dpa_props is bound.
 */
`timescale 1ns/100ps
module dpa_top_bench;
    import dpa_pkg::*;
    localparam int NPIN = 24;
    logic            clk_sys = 1'b0;
    logic            rst = 1'b1;
    logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [AW-1:0]   paddr = 16'h0;
    logic [DW-1:0]   pwdata = 32'h0, prdata, rd;
    logic            pready, pslverr, ee_ctl_din, e;
    logic [NPIN-1:0] pin_in, pin_out, pin_oe;
    logic [NPIN-1:0] ext = 24'h00010A;
    logic            v_pulse = 1'b0, real_energy_pulse = 1'b0, aux_x_pulse = 1'b0;
    logic            ee_ctl_clock = 1'b1, ee_ctl_dout = 1'b1, ee_ctl_doe = 1'b0;
    logic            ee_ack = 1'b0;
    logic [1:0]      ee_mode;
    int              n_fail = 0, n_compared = 0, cyc = 0;

    always #20 clk_sys = ~clk_sys;

    dpa_top #(.NPIN(NPIN), .EE_DI_PIN(8)) dut (
        .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .pin_in, .pin_out, .pin_oe, .v_pulse, .real_energy_pulse,
        .aux_x_pulse, .ee_ctl_clock, .ee_ctl_dout, .ee_ctl_doe, .ee_ctl_din, .ee_mode
    );
    dpa_far_side #(.NPIN(NPIN)) far (.pin_out, .pin_oe, .ext_lvl(ext), .ee_ack, .pin_in);

    // ************************************************
    // Tasks
    // ************************************************
    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Only the bench timeout ends a wait for pready
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Settle time covers register, pin flop and input filter
    task automatic wr(input logic [AW-1:0] idx, input logic [DW-1:0] d);
        apb(1'b1, idx << 2, d);
        repeat (8) @(posedge clk_sys);
    endtask

    task automatic rdchk(input logic [AW-1:0] idx, input logic [DW-1:0] exp);
        apb(1'b0, idx << 2, 32'h0);
        chk(rd, exp);
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            final_report();
        end
    end

    // ************************************************
    // Tests
    // ************************************************
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rdchk(IDX_EEX, 32'h0);
        rdchk(IDX_PVW, 32'h0);
        rdchk(IDX_PX, 32'h0);
        rdchk(IDX_GRP0, 32'hA);
        apb(1'b0, 16'h0004, 32'h0);
        chk(e, 1'b1);
        chk(rd, 32'h0);
        $display("test reset done");
        // Data is masked by the direction held before the write
        wr(IDX_GRP0, 32'hF0);
        chk({pin_oe[3:0], pin_out[3:0]}, 8'hF0);
        wr(IDX_GRP0, 32'hF5);
        chk(pin_out[3:0], 4'h5);
        rdchk(IDX_GRP0, 32'hF5);
        wr(IDX_GRP0, 32'h30);
        wr(IDX_GRP0, 32'h3F);
        chk({pin_oe[3:0], pin_out[3:0]}, 8'h33);
        rdchk(IDX_GRP0, 32'h3B);
        wr(IDX_MAP, 32'h2);
        rdchk(IDX_GRP0, 32'h39);
        wr(IDX_GRP0, 32'h3C);
        wr(IDX_MAP, 32'h0);
        chk(pin_out[1:0], 2'h2);
        $display("test data done");
        wr(IDX_HIDIR, 32'h1);
        wr(IDX_HIDATA, 32'h1);
        chk({pin_oe[16], pin_out[16]}, 2'h3);
        wr(IDX_HIDATA, 32'h0);
        chk(pin_out[16], 1'b0);
        $display("test upper pins done");
        wr(IDX_PVW, 32'hC0);
        wr(IDX_PX, 32'h80);
        for (int p = 1; p >= 0; p--) begin
            v_pulse <= p[0];
            real_energy_pulse <= p[0];
            aux_x_pulse <= p[0];
            repeat (3) @(posedge clk_sys);
            chk({pin_out[6], pin_out[1:0]}, {3{p[0]}});
        end
        chk({pin_oe[6], pin_oe[1:0]}, 3'h7);
        wr(IDX_MAP, 32'h43);
        chk({pin_oe[6], pin_oe[1:0]}, 3'h0);
        wr(IDX_MAP, 32'h0);
        wr(IDX_PVW, 32'h0);
        wr(IDX_PX, 32'h0);
        $display("test pulses done");
        ee_ack <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr(IDX_EEX, c << 6);
            rdchk(IDX_EEX, c << 6);
            chk(ee_mode, c[1:0]);
            chk(ee_ctl_din, c == 0 || c == 3);
            if (c != 0) begin
                chk({pin_oe[2], pin_out[2]}, 2'h3);
                chk(pin_oe[3], c == 3);
            end
        end
        ee_ctl_doe <= 1'b1;
        wr(IDX_EEX, 32'h40);
        chk({pin_oe[3], pin_out[3]}, 2'h3);
        ee_ctl_doe <= 1'b0;
        wr(IDX_MAP, 32'h4);
        chk(pin_oe[2], 1'b0);
        wr(IDX_EEX, 32'h0);
        $display("test eeprom done");
        final_report();
    end
endmodule

// >>> verilog/dpa_pinmux.sv
/*
 * Pin driver: chooses level and enable of every pin from the general
 * data, the pulse routes and the serial EEPROM selector.
 * Assumes pulses and controller signals come from clk_sys logic.
 */
`timescale 1ns/100ps
module dpa_pinmux
    import dpa_pkg::*;
#(
    parameter int NPIN = 24
) (
    // Clock and reset
    input  wire logic            clk_sys,
    input  wire logic            rst,
    // Controls
    dpa_route_if.mux             rt,
    // Alternate sources
    input  wire logic            v_pulse,
    input  wire logic            real_energy_pulse,
    input  wire logic            aux_x_pulse,
    input  wire logic            ee_ctl_clock,
    input  wire logic            ee_ctl_dout,
    input  wire logic            ee_ctl_doe,
    // Pins
    output logic      [NPIN-1:0] pin_out,
    output logic      [NPIN-1:0] pin_oe
);
    logic [NPIN-1:0] out_d;
    logic [NPIN-1:0] oe_d;
    logic            ee_on;

    always_comb begin
        out_d = rt.out_data;
        oe_d  = rt.dir & ~rt.display_pin_mapping;
        ee_on = (rt.ee_sel != EEX_OFF) && !rt.display_pin_mapping[PIN_EE_CLK]
                && !rt.display_pin_mapping[PIN_EE_IO];
        if (rt.pw_en && !rt.display_pin_mapping[PIN_PW]) begin
            out_d[PIN_PW] = real_energy_pulse;
            oe_d[PIN_PW]  = 1'b1;
        end
        if (rt.pv_en && !rt.display_pin_mapping[PIN_PV]) begin
            out_d[PIN_PV] = v_pulse;
            oe_d[PIN_PV]  = 1'b1;
        end
        if (rt.px_en && !rt.display_pin_mapping[PIN_PX]) begin
            out_d[PIN_PX] = aux_x_pulse;
            oe_d[PIN_PX]  = 1'b1;
        end
        if (ee_on) begin
            out_d[PIN_EE_CLK] = ee_ctl_clock;
            oe_d[PIN_EE_CLK]  = 1'b1;
            out_d[PIN_EE_IO]  = ee_ctl_dout;
            // Split mode: data pin only ever drives, input comes elsewhere
            oe_d[PIN_EE_IO]   = (rt.ee_sel == EEX_SPLIT) ? 1'b1 : ee_ctl_doe;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_out <= '0;
            pin_oe  <= '0;
        end else begin
            pin_out <= out_d;
            pin_oe  <= oe_d;
        end
    end
endmodule

// >>> verilog/dpa_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes asynchronous pin levels; output is a clean clk_sys level.
 */
`timescale 1ns/100ps
module dpa_sync #(
    parameter int W = 24
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts only once the last two stages agree
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            level <= '0;
        end else begin
            level <= (s2_q & s3_q) | (level & (s2_q | s3_q));
        end
    end
endmodule

// >>> verilog/dpa_top.sv
/*
 * Digital pin data registers and alternate-function selection behind
 * an APB slave.
 * Assumes APB master on clk_sys, pins sampled through dpa_sync, serial
 * EEPROM controller and pulse sources in the same clock domain.
 */
// The APB interface to the registers was decided locally.
// Function
// - Data read returns pin level of first sixteen pins, zero if display pin.
// - Data write changes driven level of pins configured as outputs.
// - Data writes ignored for input pins and display pins.
// - Pins above 15 take output data from their segment control bit zero; here pin 16+n takes HIDATA bit n.
// - Nonzero selector, map bits 2,3 clear: pin 2 EEPROM clock, 3 data.
// - Selector resets to zero; 00 disables, 01 selects two-wire interface.
// - Real-energy route set and map bit 0 clear: pulse on pin 0.
// - X route set and map bit 6 clear: X pulse on pin 6.
`timescale 1ns/100ps
module dpa_top #(
    parameter int NPIN      = 24,
    parameter int EE_DI_PIN = 8
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [dpa_pkg::AW-1:0] paddr,
    input  wire logic [dpa_pkg::DW-1:0] pwdata,
    output logic      [dpa_pkg::DW-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Pins
    input  wire logic [NPIN-1:0]       pin_in,
    output logic      [NPIN-1:0]       pin_out,
    output logic      [NPIN-1:0]       pin_oe,
    // Pulse sources
    input  wire logic                  v_pulse,
    input  wire logic                  real_energy_pulse,
    input  wire logic                  aux_x_pulse,
    // Serial EEPROM controller side
    input  wire logic                  ee_ctl_clock,
    input  wire logic                  ee_ctl_dout,
    input  wire logic                  ee_ctl_doe,
    output logic                       ee_ctl_din,
    output logic      [1:0]            ee_mode
);
    import dpa_pkg::*;

    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    // Pins above the sixteen group pins have registers of their own
    localparam int NHI = NPIN - PIN_LO;

    if (NPIN <= PIN_LO || NPIN > DW) begin : g_bad_npin
        $error("NPIN must lie between 17 and 32");
    end
    if (EE_DI_PIN < 0 || EE_DI_PIN >= NPIN) begin : g_bad_di
        $error("EE_DI_PIN must name an existing pin");
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [AW-1:0] byte_addr(input logic [AW-1:0] idx);
        byte_addr = {idx[AW-3:0], 2'b00};
    endfunction

    function automatic dpa_reg_t decode(input logic [AW-1:0] a);
        logic [AW-1:0] g;
        // Bits 7:6 pick the group, so they are masked off here
        g = a & ~16'h00C0;
        if (g == byte_addr(IDX_GRP0)) begin
            decode = DPA_REG_GRP;
        end else if (a == byte_addr(IDX_EEX)) begin
            decode = DPA_REG_EEX;
        end else if (a == byte_addr(IDX_PVW)) begin
            decode = DPA_REG_PVW;
        end else if (a == byte_addr(IDX_PX)) begin
            decode = DPA_REG_PX;
        end else if (a == byte_addr(IDX_MAP)) begin
            decode = DPA_REG_MAP;
        end else if (a == byte_addr(IDX_HIDATA)) begin
            decode = DPA_REG_HIDATA;
        end else if (a == byte_addr(IDX_HIDIR)) begin
            decode = DPA_REG_HIDIR;
        end else begin
            decode = DPA_REG_NONE;
        end
    endfunction

    // Only bits enabled as output and not owned by the display take data
    function automatic logic [GRP_W-1:0] merge_out(
        input logic [GRP_W-1:0] old_v,
        input logic [GRP_W-1:0] new_v,
        input logic [GRP_W-1:0] dir_v,
        input logic [GRP_W-1:0] map_v
    );
        logic [GRP_W-1:0] m;
        m = dir_v & ~map_v;
        merge_out = (old_v & ~m) | (new_v & m);
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    logic [PIN_LO-1:0] lo_data_q;
    logic [PIN_LO-1:0] lo_dir_q;
    logic [NHI-1:0]    hi_data_q;
    logic [NHI-1:0]    hi_dir_q;
    logic [NPIN-1:0]   map_q;
    logic [1:0]        ee_sel_q;
    logic              pv_q;
    logic              pw_q;
    logic              px_q;
    logic [NPIN-1:0]   level;
    dpa_reg_t          reg_sel;
    logic [1:0]        grp;
    logic              access;
    logic              wr_go;
    logic [DW-1:0]     rd_word;
    logic [GRP_W-1:0]  grp_dir;
    logic [GRP_W-1:0]  grp_map;
    logic [GRP_W-1:0]  grp_lvl;

    // Group select rides on address bits above the word offset
    assign reg_sel = decode(paddr);
    assign grp     = paddr[GRP_SEL_LSB +: 2];
    assign access  = psel && penable && !pready;
    // Writes land only at the edge where the master sees pready high
    assign wr_go   = psel && penable && pready && pwrite;
    assign grp_dir = lo_dir_q[grp*GRP_W +: GRP_W];
    assign grp_map = map_q[grp*GRP_W +: GRP_W];
    assign grp_lvl = level[grp*GRP_W +: GRP_W];

    // ****************************************************************
    // Pin sampling
    // ****************************************************************
    // Reads see the filtered level, a few cycles behind the pin
    dpa_sync #(
        .W (NPIN)
    ) u_sync (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in (pin_in),
        .level    (level)
    );

    // ****************************************************************
    // APB handshake, one wait state
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            // One fixed wait state keeps read data a plain register
            pready <= access;
        end
    end

    always_comb begin
        // Bits a register does not use read as zero
        rd_word = '0;
        unique case (reg_sel)
            DPA_REG_GRP: begin
                rd_word[GRP_DATA_LSB +: GRP_W] = grp_lvl & ~grp_map;
                rd_word[GRP_DIR_LSB +: GRP_W]  = grp_dir;
            end
            DPA_REG_EEX:    rd_word[EEX_LSB +: 2] = ee_sel_q;
            DPA_REG_PVW: begin
                rd_word[PV_BIT] = pv_q;
                rd_word[PW_BIT] = pw_q;
            end
            DPA_REG_PX:     rd_word[PX_BIT] = px_q;
            DPA_REG_MAP:    rd_word[NPIN-1:0] = map_q;
            DPA_REG_HIDATA: rd_word[NHI-1:0] = hi_data_q;
            DPA_REG_HIDIR:  rd_word[NHI-1:0] = hi_dir_q;
            DPA_REG_NONE:   rd_word = '0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (access) begin
            // Writes return zero so stale read data never reappears
            prdata  <= pwrite ? '0 : rd_word;
            pslverr <= (reg_sel == DPA_REG_NONE);
        end
    end

    // ****************************************************************
    // General pin data and direction
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lo_data_q <= {PIN_LO{DATA_RST}};
            lo_dir_q  <= {PIN_LO{DIR_RST}};
        end else if (wr_go && reg_sel == DPA_REG_GRP) begin
            // Mask uses the direction held before this write
            lo_data_q[grp*GRP_W +: GRP_W] <= merge_out(
                lo_data_q[grp*GRP_W +: GRP_W],
                pwdata[GRP_DATA_LSB +: GRP_W], grp_dir, grp_map);
            lo_dir_q[grp*GRP_W +: GRP_W] <= pwdata[GRP_DIR_LSB +: GRP_W];
        end
    end

    // Upper pins carry their data in HIDATA, one bit per pin, pin 16 in bit zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hi_data_q <= {NHI{DATA_RST}};
            hi_dir_q  <= {NHI{DIR_RST}};
        end else if (wr_go) begin
            if (reg_sel == DPA_REG_HIDATA) begin
                hi_data_q <= pwdata[NHI-1:0];
            end
            if (reg_sel == DPA_REG_HIDIR) begin
                hi_dir_q <= pwdata[NHI-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            map_q <= {NPIN{MAP_RST}};
        end else if (wr_go && reg_sel == DPA_REG_MAP) begin
            // Display ownership masks both the driver and the read value
            map_q <= pwdata[NPIN-1:0];
        end
    end

    // ****************************************************************
    // Alternate function selects
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ee_sel_q <= EEX_RST;
            pv_q     <= ROUTE_RST;
            pw_q     <= ROUTE_RST;
            px_q     <= ROUTE_RST;
        end else if (wr_go) begin
            if (reg_sel == DPA_REG_EEX) begin
                // Codes are stored as written; the pin driver decodes them
                ee_sel_q <= pwdata[EEX_LSB +: 2];
            end
            if (reg_sel == DPA_REG_PVW) begin
                pv_q <= pwdata[PV_BIT];
                pw_q <= pwdata[PW_BIT];
            end
            // A route only takes its pin while the display leaves it free
            if (reg_sel == DPA_REG_PX) begin
                px_q <= pwdata[PX_BIT];
            end
        end
    end

    // Data input to the controller; idles high like a pulled-up bus
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ee_ctl_din <= 1'b1;
            ee_mode    <= EEX_OFF;
        end else begin
            ee_mode <= ee_sel_q;
            unique case (ee_sel_q)
                EEX_OFF:   ee_ctl_din <= 1'b1;
                EEX_SPLIT: ee_ctl_din <= level[EE_DI_PIN];
                default:   ee_ctl_din <= level[PIN_EE_IO];
            endcase
        end
    end

    // ****************************************************************
    // Pin driver
    // ****************************************************************
    // Controls travel as one bundle so the driver sees a single set
    dpa_route_if #(.NPIN (NPIN)) rt ();

    assign rt.out_data = {hi_data_q, lo_data_q};
    assign rt.dir      = {hi_dir_q, lo_dir_q};
    assign rt.display_pin_mapping  = map_q;
    assign rt.ee_sel   = ee_sel_q;
    assign rt.pv_en    = pv_q;
    assign rt.pw_en    = pw_q;
    assign rt.px_en    = px_q;

    dpa_pinmux #(
        .NPIN (NPIN)
    ) u_mux (
        .clk_sys           (clk_sys),
        .rst               (rst),
        .rt                (rt.mux),
        .v_pulse           (v_pulse),
        .real_energy_pulse (real_energy_pulse),
        .aux_x_pulse       (aux_x_pulse),
        .ee_ctl_clock      (ee_ctl_clock),
        .ee_ctl_dout       (ee_ctl_dout),
        .ee_ctl_doe        (ee_ctl_doe),
        .pin_out           (pin_out),
        .pin_oe            (pin_oe)
    );
endmodule
